//--- scpl_pkg.sv
// Constants, field layouts and carrier types for the start-up configuration page loader.
// Assumes a 16-bit register port and a 100 MHz system clock.
package scpl_pkg;

   // Register addresses on the plain register port (word addresses).
   localparam logic [15:0] PAGE3_FIRST = 16'h7818;
   localparam logic [15:0] PAGE3_LAST = 16'h781F;
   localparam logic [15:0] PAGE4_FIRST = 16'h7820;
   localparam logic [15:0] PAGE4_LAST = 16'h7827;
   localparam logic [15:0] SIG_ADDR = 16'h7827;
   localparam logic [15:0] ALIAS3_FIRST = 16'h4018;
   localparam logic [15:0] ALIAS3_LAST = 16'h401F;
   localparam logic [15:0] CTRL_ADDR = 16'h7830;
   localparam logic [15:0] STAT_ADDR = 16'h7831;

   // Control register fields.
   localparam int CTRL_DEV_MODE_BIT = 0;
   localparam int CTRL_RELOAD_BIT = 1;
   localparam int CTRL_OTP_RD_BIT = 8;
   localparam int CTRL_OTP_WR_BIT = 9;
   localparam int CTRL_EE_RD_BIT = 10;
   localparam logic CTRL_DEV_MODE_RST = 1'b0;
   localparam logic CTRL_RELOAD_RST = 1'b1;

   // Status register fields.
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_HOLD_BIT = 1;
   localparam int STAT_SIG_OK_BIT = 2;
   localparam int STAT_ABSENT_BIT = 3;

   // Page storage: words 0 to 7 are page 3, words 8 to 15 are page 4.
   localparam int CFG_WORDS = 16;
   localparam logic [3:0] PAGE4_IDX = 4'h8;
   localparam logic [3:0] LAST_IDX = 4'hF;
   localparam logic [2:0] OTP_LAST = 3'h7;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] SIG_VALID = 16'hA596;

   // External EEPROM byte addresses.
   localparam logic [5:0] EE_PAGE3_FIRST = 6'h10;
   localparam logic [5:0] EE_PAGE4_FIRST = 6'h20;
   localparam logic [5:0] EE_LAST = 6'h2F;
   localparam int EE_FIFO_WIDTH = 8;
   localparam int EE_FIFO_DEPTH = 8;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OTP_RD,
      ST_OTP_WR,
      ST_EE_LOAD,
      ST_CHECK,
      ST_OFF_HOLD
   } scpl_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } scpl_bus_req_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [2:0] addr;
      logic [15:0] wdata;
   } scpl_otp_req_t;

   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
   } scpl_otp_rsp_t;

   typedef struct packed {
      logic req;
      logic [5:0] addr;
   } scpl_ee_req_t;

   typedef struct packed {
      logic ack;
      logic absent;
      logic [7:0] rdata;
   } scpl_ee_rsp_t;

endpackage

//--- scpl_fifo.sv
// Byte FIFO between the EEPROM fetch and the word packer.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/10ps
module scpl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] PTR_MAX = AW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count_reg != CNT_FULL);
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_MAX) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_MAX) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + CW'(push) - CW'(pop);
      end
   end
endmodule

//--- scpl_loader.sv
// Loader for configuration pages 3 and 4 with OTP and EEPROM sources and signature check.
// Assumes synchronous inputs, one clock, and an OTP and EEPROM that answer each request
// with a one-cycle acknowledge.
//
// Functional notes
// - Page 3 occupies register addresses 7818h to 781Fh.
// - ON request fills page 3 from OTP unless development mode is on or reload is off.
// - OTP read command reloads page 3; OTP write command programs it.
// - Development mode with reload set fills page 3 from EEPROM bytes 10h-1Fh.
// - Even EEPROM byte goes to bits 15:8, the next odd byte to 7:0.
// - Page 4 occupies register addresses 7820h to 7827h.
// - Development mode ON fills page 4 from EEPROM bytes 20h-2Fh, same packing.
// - EEPROM read command reloads pages 3 and 4 outside power transitions.
// - After an EEPROM load for an ON request, the signature is checked first.
// - EEPROM data is valid only when the signature equals A596h.
// - Absent EEPROM or bad signature holds OFF until device reset.
// - The signature register at 7827h is 16 bits and resets to 0000h.
// - A duplicated field reached at either address shares one storage.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module scpl_loader #(
   parameter int FIFO_DEPTH = scpl_pkg::EE_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Register port
   input wire scpl_pkg::scpl_bus_req_t bus_req,
   output logic [15:0] bus_rdata,
   // Power state handshake
   input wire logic on_req,
   output logic on_grant,
   output logic hold_off,
   // OTP array
   output scpl_pkg::scpl_otp_req_t otp_req,
   input wire scpl_pkg::scpl_otp_rsp_t otp_rsp,
   // External configuration EEPROM
   output scpl_pkg::scpl_ee_req_t ee_req,
   input wire scpl_pkg::scpl_ee_rsp_t ee_rsp
);
   import scpl_pkg::*;

   scpl_state_t state_reg;
   scpl_state_t state_next;
   logic [15:0] cfg_mem_reg [CFG_WORDS];
   logic dev_mode_reg;
   logic reload_reg;
   logic on_load_reg;
   logic sig_ok_reg;
   logic absent_reg;
   logic [2:0] otp_ptr_reg;
   logic otp_req_reg;
   logic [5:0] ee_addr_reg;
   logic ee_req_reg;
   logic ee_issued_reg;
   logic [3:0] drain_idx_reg;
   logic odd_phase_reg;
   logic [7:0] hi_byte_reg;
   logic [15:0] rdata_reg;
   logic grant_reg;
   logic hold_reg;
   logic otp_we_reg;
   logic [15:0] otp_wdata_reg;

   // Address decode.
   wire [15:0] addr = bus_req.addr;
   wire hit_pages = (addr >= PAGE3_FIRST) && (addr <= PAGE4_LAST);
   wire hit_alias = (addr >= ALIAS3_FIRST) && (addr <= ALIAS3_LAST);
   wire hit_mem = hit_pages || hit_alias;
   wire [15:0] page_off = addr - PAGE3_FIRST;
   wire [15:0] alias_off = addr - ALIAS3_FIRST;
   wire [3:0] bus_idx = hit_alias ? alias_off[3:0] : page_off[3:0];
   wire bus_mem_wr = bus_req.wr && hit_mem;
   wire ctrl_wr = bus_req.wr && (addr == CTRL_ADDR);

   // Commands and ON requests are taken only while idle.
   wire idle = (state_reg == ST_IDLE);
   wire cmd_otp_rd = idle && ctrl_wr && bus_req.wdata[CTRL_OTP_RD_BIT];
   wire cmd_otp_wr = idle && ctrl_wr && bus_req.wdata[CTRL_OTP_WR_BIT];
   wire cmd_ee_rd = idle && ctrl_wr && bus_req.wdata[CTRL_EE_RD_BIT];
   wire on_take = idle && on_req && !(cmd_otp_rd || cmd_otp_wr || cmd_ee_rd);

   // FIFO and word packer.
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   wire ee_ack = ee_req_reg && ee_rsp.ack;
   wire drain_ready = !bus_mem_wr;
   wire drain_pop = fifo_out_valid && drain_ready;
   wire word_wr = drain_pop && odd_phase_reg;
   wire [15:0] packed_word = {hi_byte_reg, fifo_out_data};
   wire ee_last_word = word_wr && (drain_idx_reg == LAST_IDX);
   wire ee_gone = (state_reg == ST_EE_LOAD) && ee_rsp.absent;
   // A new byte is asked for only with room in the FIFO and the EEPROM present.
   wire fetch_more = !ee_issued_reg && fifo_in_ready && !ee_rsp.absent;

   // OTP transfer progress.
   wire otp_ack = otp_req_reg && otp_rsp.ack;
   wire otp_rd_wr = otp_ack && (state_reg == ST_OTP_RD);
   wire otp_last = otp_ack && (otp_ptr_reg == OTP_LAST);

   // Storage write port: OTP reads first, then the register port; EEPROM words wait out any register-port write.
   wire mem_we = otp_rd_wr || word_wr || bus_mem_wr;
   wire [3:0] mem_idx = otp_rd_wr ? {1'b0, otp_ptr_reg} :
                        word_wr ? drain_idx_reg : bus_idx;
   wire [15:0] mem_wdata = otp_rd_wr ? otp_rsp.rdata :
                           word_wr ? packed_word : bus_req.wdata;

   // Read data selection.
   wire [15:0] ctrl_rdata = {14'h0000, reload_reg, dev_mode_reg};
   wire [15:0] stat_rdata = {12'h000, absent_reg, sig_ok_reg, hold_off, !idle};
   wire [15:0] rdata_next = hit_mem ? cfg_mem_reg[bus_idx] :
                            (addr == CTRL_ADDR) ? ctrl_rdata :
                            (addr == STAT_ADDR) ? stat_rdata : 16'h0000;

   // Source selection for an ON request.
   wire on_ee = dev_mode_reg;
   wire on_otp = !dev_mode_reg && reload_reg;
   wire [5:0] ee_start = (cmd_ee_rd || reload_reg) ? EE_PAGE3_FIRST : EE_PAGE4_FIRST;
   wire [3:0] idx_start = (cmd_ee_rd || reload_reg) ? 4'h0 : PAGE4_IDX;
   wire sig_ok = (cfg_mem_reg[LAST_IDX] == SIG_VALID);

   // Next values of the registered outputs.
   wire hold_next = (state_next == ST_OFF_HOLD);
   wire otp_we_next = (state_next == ST_OTP_WR);
   wire [15:0] otp_wdata_next = cfg_mem_reg[{1'b0, otp_ptr_reg}];

   scpl_fifo #(
      .WIDTH(EE_FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(ee_ack),
      .in_ready(fifo_in_ready),
      .in_data(ee_rsp.rdata),
      .out_valid(fifo_out_valid),
      .out_ready(drain_ready),
      .out_data(fifo_out_data)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_otp_rd) begin
               state_next = ST_OTP_RD;
            end else if (cmd_otp_wr) begin
               state_next = ST_OTP_WR;
            end else if (cmd_ee_rd) begin
               state_next = ST_EE_LOAD;
            end else if (on_take && on_ee) begin
               state_next = ST_EE_LOAD;
            end else if (on_take && on_otp) begin
               state_next = ST_OTP_RD;
            end
         end
         ST_OTP_RD, ST_OTP_WR: begin
            if (otp_last) begin
               state_next = ST_IDLE;
            end
         end
         ST_EE_LOAD: begin
            if (ee_gone) begin
               state_next = on_load_reg ? ST_OFF_HOLD : ST_IDLE;
            end else if (ee_last_word) begin
               state_next = on_load_reg ? ST_CHECK : ST_IDLE;
            end
         end
         ST_CHECK: begin
            state_next = sig_ok ? ST_IDLE : ST_OFF_HOLD;
         end
         ST_OFF_HOLD: begin
            state_next = ST_OFF_HOLD;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         dev_mode_reg <= CTRL_DEV_MODE_RST;
         reload_reg <= CTRL_RELOAD_RST;
         on_load_reg <= 1'b0;
         sig_ok_reg <= 1'b0;
         absent_reg <= 1'b0;
         rdata_reg <= 16'h0000;
         grant_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         rdata_reg <= bus_req.rd ? rdata_next : 16'h0000;
         if (ctrl_wr) begin
            dev_mode_reg <= bus_req.wdata[CTRL_DEV_MODE_BIT];
            reload_reg <= bus_req.wdata[CTRL_RELOAD_BIT];
         end
         if (idle) begin
            on_load_reg <= on_take;
         end
         if (state_reg == ST_CHECK) begin
            sig_ok_reg <= sig_ok;
         end
         if (ee_gone) begin
            absent_reg <= 1'b1;
         end
         grant_reg <= (on_take && !on_ee && !on_otp) ||
                      (on_load_reg && otp_last && state_reg == ST_OTP_RD) ||
                      (state_reg == ST_CHECK && sig_ok);
      end
   end

   // Registered outputs, so each port comes straight from a flip-flop.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hold_reg <= 1'b0;
         otp_we_reg <= 1'b0;
         otp_wdata_reg <= CFG_RST;
      end else begin
         hold_reg <= hold_next;
         otp_we_reg <= otp_we_next;
         otp_wdata_reg <= otp_wdata_next;
      end
   end

   // Page storage shared by both address windows.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < CFG_WORDS; i++) begin
            cfg_mem_reg[i] <= CFG_RST;
         end
      end else if (mem_we) begin
         cfg_mem_reg[mem_idx] <= mem_wdata;
      end
   end

   // OTP word sequencer.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         otp_ptr_reg <= 3'h0;
         otp_req_reg <= 1'b0;
      end else if (state_reg == ST_OTP_RD || state_reg == ST_OTP_WR) begin
         otp_req_reg <= !otp_ack && !otp_last;
         if (otp_ack) begin
            otp_ptr_reg <= otp_ptr_reg + 3'h1;
         end
      end else begin
         otp_ptr_reg <= 3'h0;
         otp_req_reg <= 1'b0;
      end
   end

   // EEPROM byte fetch and word packer.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ee_addr_reg <= 6'h00;
         ee_req_reg <= 1'b0;
         ee_issued_reg <= 1'b0;
         drain_idx_reg <= 4'h0;
         odd_phase_reg <= 1'b0;
         hi_byte_reg <= 8'h00;
      end else if (state_reg == ST_EE_LOAD) begin
         // Hold each byte request until its acknowledge arrives.
         if (ee_req_reg) begin
            ee_req_reg <= !ee_ack;
         end else begin
            ee_req_reg <= fetch_more;
         end
         if (ee_ack) begin
            ee_addr_reg <= ee_addr_reg + 6'h01;
            ee_issued_reg <= (ee_addr_reg == EE_LAST);
         end
         if (drain_pop) begin
            odd_phase_reg <= !odd_phase_reg;
            if (!odd_phase_reg) begin
               hi_byte_reg <= fifo_out_data;
            end else begin
               drain_idx_reg <= drain_idx_reg + 4'h1;
            end
         end
      end else begin
         ee_req_reg <= 1'b0;
         ee_issued_reg <= 1'b0;
         odd_phase_reg <= 1'b0;
         if (idle) begin
            ee_addr_reg <= ee_start;
            drain_idx_reg <= idx_start;
         end
      end
   end

   assign bus_rdata = rdata_reg;
   assign on_grant = grant_reg;
   assign hold_off = hold_reg;
   assign otp_req.req = otp_req_reg;
   assign otp_req.we = otp_we_reg;
   assign otp_req.addr = otp_ptr_reg;
   assign otp_req.wdata = otp_wdata_reg;
   assign ee_req.req = ee_req_reg;
   assign ee_req.addr = ee_addr_reg;
endmodule

//--- scpl_loader_props.sv
// Concurrent checks on the ports of the configuration page loader.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module scpl_loader_chk import scpl_pkg::*; #(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Register port
   input wire scpl_pkg::scpl_bus_req_t bus_req,
   input wire logic [15:0] bus_rdata,
   // Power state handshake
   input wire logic on_req,
   input wire logic on_grant,
   input wire logic hold_off,
   // OTP array
   input wire scpl_pkg::scpl_otp_req_t otp_req,
   input wire scpl_pkg::scpl_otp_rsp_t otp_rsp,
   // External configuration EEPROM
   input wire scpl_pkg::scpl_ee_req_t ee_req,
   input wire scpl_pkg::scpl_ee_rsp_t ee_rsp
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence otp_ack_s;
      otp_req.req && otp_rsp.ack;
   endsequence
   sequence otp_next_s;
      !otp_req.req ##1 (otp_req.req && otp_req.addr == $past(otp_req.addr, 2) + 3'h1);
   endsequence
   grant_pulse_a: assert property (on_grant |=> !on_grant)
      else $error("on_grant wider than one cycle");
   hold_latch_a: assert property (hold_off |=> hold_off)
      else $error("hold_off released without reset");
   hold_nogrant_a: assert property (hold_off |-> !on_grant)
      else $error("grant while held off");
   rd_quiet_a: assert property (!bus_req.rd |=> bus_rdata == 16'h0000)
      else $error("read data outside read answer");
   otp_stall_a: assert property (otp_req.req && !otp_rsp.ack |=>
      otp_req.req && $stable(otp_req.addr) && $stable(otp_req.we))
      else $error("OTP request changed before ack");
   otp_gap_a: assert property (otp_ack_s |=> !otp_req.req)
      else $error("OTP request held after ack");
   otp_step_a: assert property (otp_ack_s and otp_req.addr != 3'h7 |=> otp_next_s)
      else $error("OTP word order broken");
   ee_stall_a: assert property (ee_req.req && !ee_rsp.ack |=>
      ee_req.req && $stable(ee_req.addr))
      else $error("EEPROM request changed before ack");
   ee_range_a: assert property (ee_req.req |->
      ee_req.addr >= 6'h10 && ee_req.addr <= 6'h2F)
      else $error("EEPROM address out of range");
endmodule
bind scpl_loader scpl_loader_chk #(.FIFO_DEPTH(FIFO_DEPTH)) scpl_loader_chk_i (
   .clk_sys(clk_sys), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .on_req(on_req), .on_grant(on_grant), .hold_off(hold_off), .otp_req(otp_req),
   .otp_rsp(otp_rsp), .ee_req(ee_req), .ee_rsp(ee_rsp));

//--- scpl_mem_model.sv
// Behavioural OTP array and external configuration EEPROM.
// Assumes requests held until a one-cycle acknowledge, delayed by dly cycles.
`timescale 1ns/10ps
module scpl_mem_model import scpl_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // OTP side
   input wire scpl_pkg::scpl_otp_req_t otp_req,
   output scpl_pkg::scpl_otp_rsp_t otp_rsp = '0,
   // EEPROM side
   input wire scpl_pkg::scpl_ee_req_t ee_req,
   output scpl_pkg::scpl_ee_rsp_t ee_rsp = '0,
   // Behaviour controls
   input wire logic [1:0] dly,
   input wire logic absent,
   input wire logic sig_good
);
   logic [15:0] otp_mem [8];
   logic [1:0] otp_cnt = 2'h0;
   logic [1:0] ee_cnt = 2'h0;
   // Signature bytes sit at 2Eh and 2Fh, everything else is a fixed pattern.
   function automatic logic [7:0] ee_byte(input logic [5:0] a);
      if (a == 6'h2E) return sig_good ? 8'hA5 : 8'h5A;
      if (a == 6'h2F) return sig_good ? 8'h96 : 8'h69;
      return {2'b00, a} ^ 8'hA3;
   endfunction
   // Idle data lines keep changing so stale values are never mistaken for answers.
   always @(posedge clk_sys) begin
      otp_rsp.ack <= 1'b0;
      ee_rsp.ack <= 1'b0;
      otp_rsp.rdata <= ~otp_rsp.rdata;
      ee_rsp.rdata <= ee_rsp.rdata + 8'h3B;
      ee_rsp.absent <= absent;
      otp_cnt <= otp_req.req ? otp_cnt + 2'h1 : 2'h0;
      ee_cnt <= ee_req.req ? ee_cnt + 2'h1 : 2'h0;
      if (!srst && otp_req.req && !otp_rsp.ack && otp_cnt >= dly) begin
         otp_rsp.ack <= 1'b1;
         otp_cnt <= 2'h0;
         otp_rsp.rdata <= otp_mem[otp_req.addr];
         if (otp_req.we) otp_mem[otp_req.addr] <= otp_req.wdata;
      end
      if (!srst && !absent && ee_req.req && !ee_rsp.ack && ee_cnt >= dly) begin
         ee_rsp.ack <= 1'b1;
         ee_cnt <= 2'h0;
         ee_rsp.rdata <= ee_byte(ee_req.addr);
      end
   end
endmodule

//--- scpl_loader_test.sv
// Self-checking bench for the configuration page loader.
// Assumes the memory model on the far side and the bound checker.
`timescale 1ns/10ps
module scpl_loader_test;
   import scpl_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   scpl_bus_req_t bus_req = '0;
   logic [15:0] bus_rdata;
   logic on_req = 1'b0;
   logic on_grant, hold_off, got;
   scpl_otp_req_t otp_req;
   scpl_otp_rsp_t otp_rsp;
   scpl_ee_req_t ee_req;
   scpl_ee_rsp_t ee_rsp;
   logic [1:0] dly = 2'h0;
   logic absent = 1'b0;
   logic sig_good = 1'b1;
   logic [15:0] rd_val;
   logic [15:0] page [16];
   int miscompares = 0;
   int tests_run = 0;
   scpl_loader scpl_loader_i (.clk_sys(clk_sys), .srst(srst), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .on_req(on_req), .on_grant(on_grant), .hold_off(hold_off),
      .otp_req(otp_req), .otp_rsp(otp_rsp), .ee_req(ee_req), .ee_rsp(ee_rsp));
   scpl_mem_model scpl_mem_model_i (.clk_sys(clk_sys), .srst(srst), .otp_req(otp_req),
      .otp_rsp(otp_rsp), .ee_req(ee_req), .ee_rsp(ee_rsp), .dly(dly), .absent(absent),
      .sig_good(sig_good));
   initial forever #5 clk_sys = ~clk_sys;
   // Word k of pages 3 and 4 as packed from the EEPROM.
   function automatic logic [15:0] ee_word(input int k, input logic good);
      logic [7:0] a;
      a = 8'h10 + 8'(2 * k);
      if (k == 15) return good ? 16'hA596 : 16'h5A69;
      return {a ^ 8'hA3, (a + 8'h01) ^ 8'hA3};
   endfunction
   task final_report;
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task check(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   task bus_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bus_req <= '{1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask
   task rd_chk(input string n, input logic [15:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      bus_req <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1 rd_val = bus_rdata;
      if (n != "") check(n, e, rd_val);
   endtask
   task wait_idle;
      for (int i = 0; i < 300; i++) begin
         rd_chk("", STAT_ADDR, 16'h0000);
         if (rd_val[STAT_BUSY_BIT] === 1'b0) return;
      end
      check("busy timeout", 16'h0000, 16'h0001);
      final_report;
   endtask
   task power_on(output logic g);
      @(posedge clk_sys);
      on_req <= 1'b1;
      @(posedge clk_sys);
      on_req <= 1'b0;
      for (int i = 0; i < 600; i++) begin
         #1;
         g = on_grant;
         if (on_grant === 1'b1 || hold_off === 1'b1) return;
         @(posedge clk_sys);
         dly <= 2'($urandom);
      end
      check("grant timeout", 16'h0000, 16'h0001);
      final_report;
   endtask
   task do_reset;
      srst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
   endtask
   initial begin
      void'($urandom(95198));
      do_reset;
      rd_chk("signature", SIG_ADDR, 16'h0000);
      rd_chk("unmapped", 16'h7828, 16'h0000);
      for (int k = 0; k < 16; k++) begin
         page[k] = 16'($urandom);
         bus_wr(PAGE3_FIRST + 16'(k), page[k]);
      end
      for (int k = 0; k < 16; k++) begin
         rd_chk("page", PAGE3_FIRST + 16'(k), page[k]);
      end
      for (int k = 0; k < 8; k++) rd_chk("alias", ALIAS3_FIRST + 16'(k), page[k]);
      // Program OTP, clear page 3, read it back from OTP.
      bus_wr(CTRL_ADDR, 16'h0202);
      wait_idle;
      for (int k = 0; k < 8; k++) bus_wr(PAGE3_FIRST + 16'(k), 16'h0000);
      bus_wr(CTRL_ADDR, 16'h0102);
      wait_idle;
      for (int k = 0; k < 8; k++) rd_chk("otp read", PAGE3_FIRST + 16'(k), page[k]);
      // Power-on refill from OTP over scrambled contents.
      for (int k = 0; k < 8; k++) bus_wr(PAGE3_FIRST + 16'(k), ~page[k]);
      power_on(got);
      check("grant otp", 16'h0001, {15'h0000, got});
      for (int k = 0; k < 8; k++) rd_chk("otp on", PAGE3_FIRST + 16'(k), page[k]);
      // No source: contents stay; then the EEPROM read command reloads pages 3 and 4.
      bus_wr(CTRL_ADDR, 16'h0000);
      bus_wr(PAGE3_FIRST, 16'h5C3A);
      power_on(got);
      check("grant none", 16'h0001, {15'h0000, got});
      rd_chk("kept", PAGE3_FIRST, 16'h5C3A);
      bus_wr(CTRL_ADDR, 16'h0400);
      wait_idle;
      for (int k = 0; k < 16; k++) begin
         rd_chk("ee read", PAGE3_FIRST + 16'(k), ee_word(k, 1'b1));
      end
      // Development mode without reload: only page 4 refills.
      for (int k = 0; k < 16; k++) bus_wr(PAGE3_FIRST + 16'(k), 16'h0000);
      bus_wr(CTRL_ADDR, 16'h0001);
      power_on(got);
      check("grant dev", 16'h0001, {15'h0000, got});
      for (int k = 0; k < 8; k++) rd_chk("dev keep", PAGE3_FIRST + 16'(k), 16'h0000);
      for (int k = 8; k < 16; k++) begin
         rd_chk("dev on", PAGE3_FIRST + 16'(k), ee_word(k, 1'b1));
      end
      rd_chk("status dev", STAT_ADDR, 16'h0004);
      // Bad signature, then absent EEPROM: both hold the device off.
      for (int f = 0; f < 2; f++) begin
         sig_good <= 1'b0;
         absent <= f[0];
         do_reset;
         bus_wr(CTRL_ADDR, 16'h0003);
         power_on(got);
         check("grant fault", 16'h0000, {15'h0000, got});
         rd_chk("", STAT_ADDR, 16'h0000);
         check("hold", 16'h0001, {15'h0000, rd_val[STAT_HOLD_BIT]});
         check("status", {12'h000, f[0], 3'b011}, rd_val);
         if (f == 0) rd_chk("dev page3", PAGE3_FIRST + 16'h0001, ee_word(1, 1'b0));
      end
      absent <= 1'b0;
      do_reset;
      #1 check("release", 16'h0000, {15'h0000, hold_off});
      final_report;
   end
endmodule
